// ==== verilog/swctl_pkg.sv ====
// constants and field layout of the switch global control registers
`default_nettype none
package swctl_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam int          NUM_PORTS     = 2;
  localparam int          NUM_Q         = 4;
  // register offsets
  localparam logic [7:0]  ADDR_ID       = 8'h00;
  localparam logic [7:0]  ADDR_CTL1     = 8'h02;
  localparam logic [7:0]  ADDR_CTL2     = 8'h04;
  // reset values and second control word write mask
  localparam logic        RUN_RST       = 1'b0;
  localparam logic [15:0] CTL1_RST      = 16'h3400;
  localparam logic [15:0] CTL2_RST      = 16'h0000;
  localparam logic [15:0] CTL2_MASK     = 16'hff00;
  // identity word fields
  localparam int          ID_RUN        = 0;
  localparam int          ID_REV_LSB    = 1;
  localparam int          ID_CHIP_LSB   = 4;
  localparam int          ID_FAM_LSB    = 8;
  // first control word fields
  localparam int          B1_PASS_ALL   = 15;
  localparam int          B1_TX_PAUSE   = 13;
  localparam int          B1_RX_PAUSE   = 12;
  localparam int          B1_LEN_CHK    = 11;
  localparam int          B1_AGE_EN     = 10;
  localparam int          B1_FAST_AGE   = 9;
  localparam int          B1_AGGR_BO    = 8;
  localparam int          B1_PASS_FC    = 3;
  localparam int          B1_LC_AGE     = 0;
  // second control word fields
  localparam int          B2_VLAN       = 15;
  localparam int          B2_IGMP       = 14;
  localparam int          B2_MLD        = 13;
  localparam int          B2_MLD_OPT    = 12;
  localparam int          B2_WFQ        = 11;
  localparam int          B2_SNIFF_AND  = 8;
  // frame length check limit
  localparam logic [15:0] LEN_LIMIT     = 16'h05dc;
  // timing
  localparam longint      CLK_HZ        = 25000000;
  localparam longint      AGE_NORMAL_S  = 300;
  localparam longint      AGE_FAST_US   = 800;
  localparam logic [32:0] AGE_NORMAL_CYC = 33'(AGE_NORMAL_S * CLK_HZ);
  localparam logic [32:0] AGE_FAST_CYC   =
    33'((AGE_FAST_US * CLK_HZ) / 64'd1000000);
endpackage
`default_nettype wire

// ==== verilog/switch_global_control_regs.sv ====
// global control and identity registers with aging, queue and sniff logic
`default_nettype none
module switch_global_control_regs #(
  parameter logic [7:0]  FAMILY_CODE       = 8'h5a, // arbitrary value
  parameter logic [3:0]  CHIP_CODE         = 4'h3,  // arbitrary value
  parameter logic [2:0]  REV_CODE          = 3'h2,  // arbitrary value
  parameter logic [32:0] AGE_NORMAL_CYCLES = swctl_pkg::AGE_NORMAL_CYC,
  parameter logic [32:0] AGE_FAST_CYCLES   = swctl_pkg::AGE_FAST_CYC
) (
  // clock and reset
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst_n,
  // register port
  input  wire logic [swctl_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [swctl_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [swctl_pkg::DATA_W-1:0]   o_rdata,
  // port link pins
  input  wire logic [swctl_pkg::NUM_PORTS-1:0] i_link_up,
  // frame length check
  input  wire logic                           i_len_valid,
  input  wire logic [15:0]                    i_len_type,
  input  wire logic [15:0]                    i_frame_len,
  // output queue scheduling
  input  wire logic                           i_tx_slot,
  input  wire logic [swctl_pkg::NUM_Q-1:0]    i_q_ready,
  output logic      [swctl_pkg::NUM_Q-1:0]    o_q_grant,
  output logic                                o_grant_valid,
  // sniffing
  input  wire logic                           i_sniff_on,
  input  wire logic                           i_sniff_chk,
  input  wire logic                           i_src_match,
  input  wire logic                           i_dst_match,
  output logic                                o_mirror,
  // controls to the switch core
  output logic                                o_switch_en,
  output logic                                o_pass_bad,
  output logic                                o_tx_pause_en,
  output logic                                o_rx_pause_en,
  output logic                                o_len_drop,
  output logic                                o_age_tick,
  output logic                                o_flush_all,
  output logic                                o_aggr_backoff,
  output logic                                o_pass_fc,
  output logic                                o_vlan_en,
  output logic                                o_igmp_snoop,
  output logic                                o_mld_snoop,
  output logic                                o_mld_opt
);
  import swctl_pkg::*;

  typedef struct packed {
    logic                 run;
    logic [15:0]          ctl1;
    logic [15:0]          ctl2;
    logic [15:0]          rdata;
    logic [NUM_PORTS-1:0] link_s1;
    logic [NUM_PORTS-1:0] link_s2;
    logic [NUM_PORTS-1:0] link_s3;
    logic [NUM_PORTS-1:0] link;
    logic                 flush;
    logic                 lc_pend;
    logic [32:0]          age_cnt;
    logic                 age_tick;
    logic [15:0]          credit;
    logic [3:0]           grant;
    logic                 gvalid;
    logic                 mirror;
    logic                 pass_bad;
    logic                 len_drop;
  } state_s;

  state_s st;
  state_s next_st;

  // highest set bit as one-hot
  function automatic logic [3:0] top_bit(input logic [3:0] v);
    logic [3:0] r;
    r = 4'h0;
    if (v[3]) begin
      r = 4'h8;
    end else if (v[2]) begin
      r = 4'h4;
    end else if (v[1]) begin
      r = 4'h2;
    end else if (v[0]) begin
      r = 4'h1;
    end
    return r;
  endfunction

  // per-round credits: 8:4:2:1, plus one for the top ready queue unless all are ready; empty queues get none
  function automatic logic [15:0] wfq_weights(input logic [3:0] rdy);
    logic [15:0] w;
    logic [3:0]  h;
    w = 16'h0000;
    h = top_bit(rdy);
    for (int i = 0; i < 4; i++) begin
      w[i*4 +: 4] = rdy[i] ?
        4'((4'h1 << i) + {3'h0, h[i] & ~(&rdy)}) : 4'h0;
    end
    return w;
  endfunction

  logic                 age_on;
  logic [32:0]          reload;
  logic [NUM_PORTS-1:0] settled;
  logic                 drop;
  logic [3:0]           has_cr;
  logic [3:0]           elig;
  logic [15:0]          cr;

  always_comb begin
    next_st = st;
    // one-cycle outputs fall back to idle
    next_st.rdata    = 16'h0000;
    next_st.age_tick = 1'b0;
    next_st.flush    = 1'b0;
    next_st.gvalid   = 1'b0;
    next_st.grant    = 4'h0;
    next_st.mirror   = 1'b0;
    next_st.len_drop = 1'b0;

    // register writes; identity fields have no storage
    if (i_wr) begin
      unique case (i_addr)
        ADDR_ID:   next_st.run  = i_wdata[ID_RUN];
        ADDR_CTL1: next_st.ctl1 = i_wdata;
        ADDR_CTL2: next_st.ctl2 = i_wdata & CTL2_MASK;
        default: ;
      endcase
    end
    // read data stand in the following cycle only
    if (i_rd) begin
      unique case (i_addr)
        ADDR_ID:   next_st.rdata = {FAMILY_CODE, CHIP_CODE, REV_CODE,
                                    st.run};
        ADDR_CTL1: next_st.rdata = st.ctl1;
        ADDR_CTL2: next_st.rdata = st.ctl2;
        default:   next_st.rdata = 16'h0000;
      endcase
    end

    // link pins: a change counts when stages two and three agree
    next_st.link_s1 = i_link_up;
    next_st.link_s2 = st.link_s1;
    next_st.link_s3 = st.link_s2;
    settled = ~(st.link_s2 ^ st.link_s3);
    drop = |(st.link & ~st.link_s3 & settled);
    next_st.link = (st.link & ~settled) | (st.link_s3 & settled);

    // aging timer; a pending link-change cycle forces the fast period
    age_on = st.run & st.ctl1[B1_AGE_EN];
    reload = (st.ctl1[B1_FAST_AGE] | st.lc_pend) ?
             AGE_FAST_CYCLES - 33'h1 : AGE_NORMAL_CYCLES - 33'h1;
    if (!age_on) begin
      next_st.age_cnt = reload;
    end else if (st.age_cnt == 33'h0) begin
      next_st.age_tick = 1'b1;
      next_st.lc_pend  = 1'b0;
      next_st.age_cnt  = st.ctl1[B1_FAST_AGE] ?
        AGE_FAST_CYCLES - 33'h1 : AGE_NORMAL_CYCLES - 33'h1;
    end else begin
      next_st.age_cnt = st.age_cnt - 33'h1;
    end
    // link loss: flush all, and maybe one fast cycle; set beats clear
    if (drop) begin
      next_st.flush = 1'b1;
      if (st.ctl1[B1_LC_AGE]) begin
        next_st.lc_pend = 1'b1;
        next_st.age_cnt = AGE_FAST_CYCLES - 33'h1;
      end
    end

    // queue pick per transmit slot
    cr = st.credit;
    for (int i = 0; i < 4; i++) begin
      has_cr[i] = cr[i*4 +: 4] != 4'h0;
    end
    elig = i_q_ready & has_cr;
    if (i_tx_slot && |i_q_ready) begin
      next_st.gvalid = 1'b1;
      if (!st.ctl2[B2_WFQ]) begin
        next_st.grant = top_bit(i_q_ready);
      end else begin
        // round used up for waiting queues: refill from live weights
        if (elig == 4'h0) begin
          cr   = wfq_weights(i_q_ready);
          elig = i_q_ready;
        end
        next_st.grant = top_bit(elig);
        for (int i = 0; i < 4; i++) begin
          if (next_st.grant[i]) begin
            cr[i*4 +: 4] = cr[i*4 +: 4] - 4'h1;
          end
        end
        next_st.credit = cr;
      end
    end

    // sniff match: both ports or either one
    if (i_sniff_chk) begin
      next_st.mirror = st.ctl2[B2_SNIFF_AND] ?
        (i_src_match & i_dst_match) : (i_src_match | i_dst_match);
    end

    // bad frames only pass while the sniffer is active
    next_st.pass_bad = st.ctl1[B1_PASS_ALL] & i_sniff_on;

    // short length field must equal the real frame length
    if (i_len_valid && st.ctl1[B1_LEN_CHK] && i_len_type < LEN_LIMIT &&
        i_len_type != i_frame_len) begin
      next_st.len_drop = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st         <= '0;
      st.run     <= RUN_RST;
      st.ctl1    <= CTL1_RST;
      st.ctl2    <= CTL2_RST;
      st.age_cnt <= AGE_NORMAL_CYCLES - 33'h1;
    end else begin
      st <= next_st;
    end
  end

  // everything below is a flip-flop or a stored control bit
  assign o_rdata        = st.rdata;
  assign o_switch_en    = st.run;
  assign o_pass_bad     = st.pass_bad;
  assign o_tx_pause_en  = st.ctl1[B1_TX_PAUSE];
  assign o_rx_pause_en  = st.ctl1[B1_RX_PAUSE];
  assign o_len_drop     = st.len_drop;
  assign o_age_tick     = st.age_tick;
  assign o_flush_all    = st.flush;
  assign o_aggr_backoff = st.ctl1[B1_AGGR_BO];
  assign o_pass_fc      = st.ctl1[B1_PASS_FC];
  assign o_vlan_en      = st.ctl2[B2_VLAN];
  assign o_igmp_snoop   = st.ctl2[B2_IGMP];
  assign o_mld_snoop    = st.ctl2[B2_MLD];
  assign o_mld_opt      = st.ctl2[B2_MLD_OPT];
  assign o_q_grant      = st.grant;
  assign o_grant_valid  = st.gvalid;
  assign o_mirror       = st.mirror;

  a_run_reset: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> !o_switch_en && !o_vlan_en && !o_mld_snoop)
    else $error("switch not idle after reset");

  a_run_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_wr && i_addr == ADDR_ID |=> o_switch_en == $past(i_wdata[0]))
    else $error("run bit not taken from write");

  a_id_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rd && i_addr == ADDR_ID |=>
      o_rdata[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
    else $error("identity fields changed");

  a_pass_bad: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_pass_bad |-> $past(i_sniff_on) && $past(st.ctl1[B1_PASS_ALL]))
    else $error("bad frames passed outside sniffer mode");

  a_tx_pause: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_wr && i_addr == ADDR_CTL1 && !i_wdata[B1_TX_PAUSE] |=>
      !o_tx_pause_en ##1 (!o_tx_pause_en || $past(i_wr)))
    else $error("tx pause still enabled");

  a_rx_pause: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_wr && i_addr == ADDR_CTL1 |=>
      o_rx_pause_en == $past(i_wdata[B1_RX_PAUSE]))
    else $error("rx pause enable wrong");

  a_len_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_len_drop |-> $past(i_len_type) < LEN_LIMIT &&
      $past(i_len_type) != $past(i_frame_len) && $past(st.ctl1[B1_LEN_CHK]))
    else $error("length drop without cause");

  a_age_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !age_on && !drop |=> !o_age_tick ##1 !o_age_tick)
    else $error("aging while disabled");

  a_fast_age: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    age_on && st.ctl1[B1_FAST_AGE] && st.age_cnt == 33'h0 |=>
      o_age_tick && st.age_cnt == AGE_FAST_CYCLES - 33'h1)
    else $error("fast age period wrong");

  a_link_age: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    drop && st.ctl1[B1_LC_AGE] |=>
      st.lc_pend && st.age_cnt == AGE_FAST_CYCLES - 33'h1)
    else $error("link loss gave no fast age");

  a_link_flush: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    drop |=> o_flush_all)
    else $error("link loss gave no flush");

  a_strict_pri: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_tx_slot && |i_q_ready && !st.ctl2[B2_WFQ] |=>
      o_grant_valid && o_q_grant == top_bit($past(i_q_ready)))
    else $error("strict priority pick wrong");

  a_sniff_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_sniff_chk && st.ctl2[B2_SNIFF_AND] && !i_dst_match |=> !o_mirror)
    else $error("mirror without both ports matching");

endmodule // switch_global_control_regs
`default_nettype wire

// ==== verification/tb_switch_global_control_regs.sv ====
// self-checking bench for the switch global control registers
`default_nettype none
module tb_switch_global_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import swctl_pkg::*;
  localparam int AGE_N = 200; // shortened periods keep the run brief
  localparam int AGE_F = 20;
  localparam logic [7:0] FAM = 8'h5a; // arbitrary value
  localparam logic [3:0] CHIP = 4'h3; // arbitrary value
  localparam logic [2:0] REV = 3'h2; // arbitrary value
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_len_valid = 1'b0;
  logic [1:0]  i_link_up = 2'h3;
  logic [15:0] i_len_type = 16'h0000, i_frame_len = 16'h0000;
  logic        i_tx_slot = 1'b0, i_sniff_on = 1'b0, i_sniff_chk = 1'b0;
  logic [3:0]  i_q_ready = 4'h0;
  logic        i_src_match = 1'b0, i_dst_match = 1'b0;
  logic [15:0] o_rdata;
  logic [3:0]  o_q_grant;
  logic        o_grant_valid, o_mirror, o_switch_en, o_pass_bad;
  logic        o_tx_pause_en, o_rx_pause_en, o_len_drop, o_age_tick;
  logic        o_flush_all, o_aggr_backoff, o_pass_fc, o_vlan_en;
  logic        o_igmp_snoop, o_mld_snoop, o_mld_opt;
  int          err_total = 0, n_checks = 0;
  logic [15:0] d;
  int          g;
  always #20 i_ref_clk = ~i_ref_clk;
  switch_global_control_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP),
    .REV_CODE(REV), .AGE_NORMAL_CYCLES(33'd200),
    .AGE_FAST_CYCLES(33'd20)) i_switch_global_control_regs (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_link_up(i_link_up), .i_len_valid(i_len_valid),
    .i_len_type(i_len_type), .i_frame_len(i_frame_len),
    .i_tx_slot(i_tx_slot), .i_q_ready(i_q_ready), .o_q_grant(o_q_grant),
    .o_grant_valid(o_grant_valid), .i_sniff_on(i_sniff_on),
    .i_sniff_chk(i_sniff_chk), .i_src_match(i_src_match),
    .i_dst_match(i_dst_match), .o_mirror(o_mirror),
    .o_switch_en(o_switch_en), .o_pass_bad(o_pass_bad),
    .o_tx_pause_en(o_tx_pause_en), .o_rx_pause_en(o_rx_pause_en),
    .o_len_drop(o_len_drop), .o_age_tick(o_age_tick),
    .o_flush_all(o_flush_all), .o_aggr_backoff(o_aggr_backoff),
    .o_pass_fc(o_pass_fc), .o_vlan_en(o_vlan_en),
    .o_igmp_snoop(o_igmp_snoop), .o_mld_snoop(o_mld_snoop),
    .o_mld_opt(o_mld_opt));
  task automatic chk_w(string n, logic [15:0] e, logic [15:0] v);
    n_checks++;
    if (v !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic chk_b(string n, logic e, logic v);
    chk_w(n, {15'h0, e}, {15'h0, v});
  endtask
  task automatic chk_i(string n, int e, int v);
    n_checks++;
    if (v != e) begin
      err_total++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, v);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge i_ref_clk);
    i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge i_ref_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic t_regs;
    rd(ADDR_ID); chk_w("id", {FAM, CHIP, REV, 1'b0}, d);
    @(posedge i_ref_clk); #1 chk_w("rdata idle", 16'h0, o_rdata);
    rd(ADDR_CTL1); chk_w("ctl1 rst", 16'h3400, d);
    rd(ADDR_CTL2); chk_w("ctl2 rst", 16'h0000, d);
    chk_b("run rst", 1'b0, o_switch_en);
    wr(ADDR_ID, 16'hffff); rd(ADDR_ID);
    chk_w("id ro", {FAM, CHIP, REV, 1'b1}, d);
    chk_b("run on", 1'b1, o_switch_en);
    wr(8'h06, 16'hffff); rd(8'h06); chk_w("unmapped", 16'h0, d);
    wr(ADDR_CTL1, 16'hffff); rd(ADDR_CTL1); chk_w("ctl1", 16'hffff, d);
    chk_w("c1 outs", 4'hf, {o_tx_pause_en, o_rx_pause_en, o_aggr_backoff,
      o_pass_fc});
    wr(ADDR_CTL2, 16'hffff); rd(ADDR_CTL2); chk_w("ctl2", 16'hff00, d);
    chk_w("c2 outs", 4'hf, {o_vlan_en, o_igmp_snoop, o_mld_snoop,
      o_mld_opt});
    wr(ADDR_CTL1, 16'h8000); wr(ADDR_CTL2, 16'h0000);
    chk_w("c1 off", 4'h0, {o_tx_pause_en, o_rx_pause_en, o_aggr_backoff,
      o_pass_fc});
    chk_w("c2 off", 4'h0, {o_vlan_en, o_igmp_snoop, o_mld_snoop,
      o_mld_opt});
    repeat (2) @(posedge i_ref_clk);
    #1 chk_b("pass no sniff", 1'b0, o_pass_bad);
    @(posedge i_ref_clk);
    i_sniff_on <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 chk_b("pass sniff", 1'b1, o_pass_bad);
    wr(ADDR_ID, 16'h0000); chk_b("run off", 1'b0, o_switch_en);
    $display("test regs done");
  endtask
  task automatic len(logic [15:0] t, logic [15:0] f, logic e);
    @(posedge i_ref_clk);
    i_len_type <= t; i_frame_len <= f; i_len_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_len_valid <= 1'b0;
    #1 chk_b("len drop", e, o_len_drop);
  endtask
  task automatic t_len;
    len(16'd100, 16'd200, 1'b0);
    wr(ADDR_CTL1, 16'h3c00);
    len(16'd100, 16'd100, 1'b0);
    len(16'd100, 16'd200, 1'b1);
    len(16'd1499, 16'd10, 1'b1);
    len(16'd1500, 16'd10, 1'b0);
    $display("test length done");
  endtask
  task automatic pick(logic [3:0] r, int n, int e3, int e2, int e1, int e0);
    int c[4];
    c = '{0, 0, 0, 0};
    i_q_ready <= r;
    @(posedge i_ref_clk);
    i_tx_slot <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge i_ref_clk);
      if (i == n - 1) i_tx_slot <= 1'b0;
      #1;
      for (int j = 0; j < 4; j++)
        if (o_grant_valid === 1'b1 && o_q_grant[j] === 1'b1) c[j]++;
    end
    chk_i("q3", e3, c[3]); chk_i("q2", e2, c[2]);
    chk_i("q1", e1, c[1]); chk_i("q0", e0, c[0]);
  endtask
  task automatic t_queue;
    pick(4'hf, 3, 3, 0, 0, 0);
    pick(4'h6, 2, 0, 2, 0, 0);
    wr(ADDR_CTL2, 16'h0800);
    pick(4'hf, 15, 8, 4, 2, 1);
    pick(4'hb, 12, 9, 0, 2, 1);
    $display("test queue done");
  endtask
  task automatic t_sniff;
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CTL2, m[0] ? 16'h0100 : 16'h0000);
      for (int k = 0; k < 4; k++) begin
        @(posedge i_ref_clk);
        {i_src_match, i_dst_match} <= k[1:0]; i_sniff_chk <= 1'b1;
        @(posedge i_ref_clk);
        i_sniff_chk <= 1'b0;
        #1 chk_b("mirror", m[0] ? &k[1:0] : |k[1:0], o_mirror);
      end
    end
    $display("test sniff done");
  endtask
  // cycles until the next age tick, limit+1 when none comes
  task automatic gap(int lim);
    g = 0;
    do begin
      @(posedge i_ref_clk);
      #1 g++;
    end while (o_age_tick !== 1'b1 && g <= lim);
  endtask
  task automatic t_aging;
    gap(AGE_N * 2); chk_i("stopped", AGE_N * 2 + 1, g);
    wr(ADDR_ID, 16'h0001);
    gap(AGE_N + 10); gap(AGE_N + 10); chk_i("normal", AGE_N, g);
    wr(ADDR_CTL1, 16'h3600);
    gap(AGE_N + 10); gap(AGE_N + 10); chk_i("fast", AGE_F, g);
    wr(ADDR_CTL1, 16'h3000);
    gap(AGE_N + 100); chk_i("age off", AGE_N + 101, g);
    wr(ADDR_CTL1, 16'h3401);
    gap(AGE_N + 10);
    i_link_up <= 2'h2;
    g = 0;
    do begin
      @(posedge i_ref_clk);
      #1 g++;
    end while (o_flush_all !== 1'b1 && g < 8);
    chk_i("flush", 4, g);
    gap(AGE_F + 10); chk_i("lc fast", AGE_F, g);
    gap(AGE_N + 10); chk_i("lc back", AGE_N, g);
    i_link_up <= 2'h3;
    $display("test aging done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_len();
    t_queue();
    t_sniff();
    t_aging();
    stop_test();
  end
endmodule // tb_switch_global_control_regs
`default_nettype wire
